// *** hw/cns_pkg.sv ***
// Constants, types and defaults for the configuration store/restore block
// Notes on behaviour
// RL1: Writing one to the commit bit copies buffered settings to active; bit self-clears.
// RL2: Twenty-three segment-list registers describe start address and byte count to move.
// RL3: Segment list may hold a commit opcode and an end-of-data opcode.
// RL4: Reset contents of the list move the whole register space, then commit.
// RL5: Status bit reads one while a transfer is running, zero when done.
// RL6: Read-only error bit reads one when a restore found bad data.
// RL7: With select pin low, soft-reload bit soft-resets and restores settings from memory.
// RL8: Soft-reload bit clears on the first serial clock edge after its write.
// RL9: Write-enable bit, zero at reset, must be one before any save is accepted.
// RL10: Save bit starts a buffer-to-memory copy and returns to zero when finished.
// RL11: A save requested while protected leaves memory untouched and starts nothing.
package cns_pkg;

	// ********************
	// Register map
	// ********************
	localparam logic [11:0] CNS_A_COMMIT = 12'h232;
	localparam logic [11:0] CNS_A_SEG0 = 12'ha00;
	localparam logic [11:0] CNS_A_STAT = 12'hb00;
	localparam logic [11:0] CNS_A_ERR = 12'hb01;
	localparam logic [11:0] CNS_A_CTRL = 12'hb02;
	localparam logic [11:0] CNS_A_SAVE = 12'hb03;
	localparam int CNS_SEG_N = 23;

	// ********************
	// Field positions
	// ********************
	localparam int CNS_B_COMMIT = 0;
	localparam int CNS_B_BUSY = 0;
	localparam int CNS_B_ERR = 0;
	localparam int CNS_B_WEN = 0;
	localparam int CNS_B_RELOAD = 1;
	localparam int CNS_B_SAVE = 0;

	// ********************
	// Segment list encoding
	// ********************
	// Entry byte: bit 7 clear = segment (count-1, then addr high nibble, addr low)
	localparam int CNS_OP_BIT = 7;
	localparam logic [7:0] CNS_OP_COMMIT = 8'h80;
	localparam logic [7:0] CNS_OP_END = 8'hff;
	localparam int CNS_NVM_AW = 10;
	localparam logic [7:0] CNS_SEG_DEF [CNS_SEG_N] = '{
		8'h7f, 8'h00, 8'h00,
		8'h7f, 8'h00, 8'h80,
		8'h7f, 8'h01, 8'h00,
		8'h7f, 8'h01, 8'h80,
		8'h31, 8'h02, 8'h00,
		8'h80, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
	};

	// ********************
	// Carriers
	// ********************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} cns_reg_req_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [11:0] addr;
		logic [7:0] wdata;
	} cns_buf_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [CNS_NVM_AW-1:0] addr;
		logic [7:0] wdata;
	} cns_nvm_req_t;

endpackage

// *** hw/cns_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cns_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] m_q;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			m_q <= '0;
			q <= '0;
		end else begin
			m_q <= d;
			q <= m_q;
		end
	end
endmodule // cns_sync

// *** hw/cns_xfer.sv ***
// Single-byte mover between buffer registers and nonvolatile memory
`timescale 1ns/1ps
module cns_xfer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Command
	input wire logic start,
	input wire logic save,
	input wire logic csum,
	input wire logic [11:0] baddr,
	input wire logic [cns_pkg::CNS_NVM_AW-1:0] naddr,
	input wire logic [7:0] csum_val,
	output logic done,
	output logic [7:0] data_q,
	// Buffer registers
	output cns_pkg::cns_buf_req_t buf_o,
	input wire logic [7:0] buf_rdata,
	// Nonvolatile memory
	output cns_pkg::cns_nvm_req_t nvm_o,
	input wire logic nvm_ack,
	input wire logic [7:0] nvm_rdata
);
	import cns_pkg::*;

	typedef enum logic [4:0] {
		X_IDLE = 5'b00001,
		X_BUF = 5'b00010,
		X_CAP = 5'b00100,
		X_NVM = 5'b01000,
		X_WB = 5'b10000
	} cns_xst_t;

	cns_xst_t st_q;
	logic save_q;
	logic csum_q;
	logic [11:0] baddr_q;
	logic [CNS_NVM_AW-1:0] naddr_q;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_q <= X_IDLE;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st_q)
				X_IDLE: begin
					if (start) begin
						st_q <= (save && !csum) ? X_BUF : X_NVM;
					end
				end
				X_BUF: st_q <= X_CAP;
				X_CAP: st_q <= X_NVM;
				X_NVM: begin
					if (nvm_ack) begin
						st_q <= (save_q || csum_q) ? X_IDLE : X_WB;
						done <= save_q || csum_q;
					end
				end
				X_WB: begin
					st_q <= X_IDLE;
					done <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			save_q <= 1'b0;
			csum_q <= 1'b0;
			baddr_q <= '0;
			naddr_q <= '0;
			data_q <= '0;
		end else if (st_q == X_IDLE && start) begin
			save_q <= save;
			csum_q <= csum;
			baddr_q <= baddr;
			naddr_q <= naddr;
			data_q <= csum_val;
		end else if (st_q == X_CAP) begin
			data_q <= buf_rdata;
		end else if (st_q == X_NVM && nvm_ack && !save_q) begin
			data_q <= nvm_rdata;
		end
	end

	always_comb begin
		buf_o.re = (st_q == X_BUF);
		buf_o.we = (st_q == X_WB);
		buf_o.addr = baddr_q;
		buf_o.wdata = data_q;
		nvm_o.req = (st_q == X_NVM);
		nvm_o.we = (st_q == X_NVM) && save_q;
		nvm_o.addr = naddr_q;
		nvm_o.wdata = data_q;
	end
endmodule // cns_xfer

// *** hw/cns_store.sv ***
// Configuration store/restore control with segment-list walker
`timescale 1ns/1ps
module cns_store (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register access from the serial control port
	input cns_pkg::cns_reg_req_t reg_i,
	output logic [7:0] reg_rdata,
	// Pins
	input wire logic spi_sclk,
	input wire logic nvm_sel_n,
	// Device events
	output logic commit_pulse,
	output logic soft_reset_pulse,
	// Buffer registers
	output cns_pkg::cns_buf_req_t buf_o,
	input wire logic [7:0] buf_rdata,
	// Nonvolatile memory
	output cns_pkg::cns_nvm_req_t nvm_o,
	input wire logic nvm_ack,
	input wire logic [7:0] nvm_rdata
);
	import cns_pkg::*;

	// ********************
	// Declarations
	// ********************
	typedef enum logic [7:0] {
		S_IDLE = 8'b00000001,
		S_FETCH = 8'b00000010,
		S_HI = 8'b00000100,
		S_LO = 8'b00001000,
		S_MOVE = 8'b00010000,
		S_WAIT = 8'b00100000,
		S_CSUM = 8'b01000000,
		S_CWAIT = 8'b10000000
	} cns_st_t;

	cns_st_t st_q;
	logic [7:0] seg_q [CNS_SEG_N];
	logic [4:0] idx_q;
	logic [6:0] cnt_q;
	logic [11:0] addr_q;
	logic [CNS_NVM_AW-1:0] nptr_q;
	logic [7:0] csum_q;
	logic dir_q;
	logic wen_q;
	logic save_q;
	logic reload_q;
	logic err_q;
	logic [1:0] pin_s;
	logic sclk_d;
	logic sclk_rise;
	logic sel_n_s;
	logic [7:0] ent;
	logic busy;
	logic save_req;
	logic start_save;
	logic rel_req;
	logic start_rest;
	logic xdone;
	logic [7:0] xdata;
	logic [11:0] roff;

	function automatic logic hit(input cns_reg_req_t r, input logic [11:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// ********************
	// Pin synchronisers
	// ********************
	cns_sync #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({spi_sclk, ~nvm_sel_n}),
		.q(pin_s)
	);

	// Synced active high so a flushed synchroniser reads deselected, not selected
	assign sel_n_s = ~pin_s[0];

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= pin_s[1];
		end
	end

	assign sclk_rise = pin_s[1] && !sclk_d;

	// ********************
	// Request decode
	// ********************
	assign busy = (st_q != S_IDLE);
	assign ent = (idx_q < 5'(CNS_SEG_N)) ? seg_q[idx_q] : CNS_OP_END;
	assign save_req = hit(reg_i, CNS_A_SAVE) && reg_i.wdata[CNS_B_SAVE];
	// RL9 RL11 protected save ignored
	assign start_save = save_req && wen_q && !busy;
	// RL7 reload only with select low
	assign rel_req = hit(reg_i, CNS_A_CTRL) && reg_i.wdata[CNS_B_RELOAD] && !sel_n_s;
	// Save wins if both arrive together, as dir_q takes start_save
	assign start_rest = rel_req && !busy;

	// ********************
	// Segment list
	// ********************
	generate
		for (genvar i = 0; i < CNS_SEG_N; i++) begin : g_seg
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					// RL4 whole space then commit
					seg_q[i] <= CNS_SEG_DEF[i];
				// RL2 list entry write
				end else if (hit(reg_i, CNS_A_SEG0 + 12'(i))) begin
					seg_q[i] <= reg_i.wdata;
				end
			end
		end
	endgenerate

	// ********************
	// Control bits
	// ********************
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wen_q <= 1'b0;
		// RL9 write-enable default zero
		end else if (hit(reg_i, CNS_A_CTRL)) begin
			wen_q <= reg_i.wdata[CNS_B_WEN];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			reload_q <= 1'b0;
		end else if (rel_req) begin
			reload_q <= 1'b1;
		// RL8 clear on serial edge
		end else if (sclk_rise) begin
			reload_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			save_q <= 1'b0;
		// RL10 save bit tracks transfer
		end else if (start_save) begin
			save_q <= 1'b1;
		end else if (st_q == S_CWAIT && xdone) begin
			save_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			err_q <= 1'b0;
		end else if (start_save || start_rest) begin
			err_q <= 1'b0;
		// RL6 checksum mismatch on restore
		end else if (st_q == S_CWAIT && xdone && !dir_q && xdata != csum_q) begin
			err_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			commit_pulse <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else begin
			// RL1 RL3 commit from bit or opcode
			commit_pulse <= (hit(reg_i, CNS_A_COMMIT) && reg_i.wdata[CNS_B_COMMIT])
				|| (st_q == S_FETCH && ent == CNS_OP_COMMIT);
			soft_reset_pulse <= rel_req;
		end
	end

	// ********************
	// Segment walker
	// ********************
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: if (start_save || start_rest) st_q <= S_FETCH;
				// RL3 opcodes steer the walk
				S_FETCH: begin
					if (!ent[CNS_OP_BIT]) begin
						st_q <= S_HI;
					end else if (ent != CNS_OP_COMMIT) begin
						st_q <= S_CSUM;
					end
				end
				S_HI: st_q <= S_LO;
				S_LO: st_q <= S_MOVE;
				S_MOVE: st_q <= S_WAIT;
				S_WAIT: if (xdone) st_q <= (cnt_q == '0) ? S_FETCH : S_MOVE;
				S_CSUM: st_q <= S_CWAIT;
				S_CWAIT: if (xdone) st_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			idx_q <= '0;
			cnt_q <= '0;
			addr_q <= '0;
			nptr_q <= '0;
			csum_q <= '0;
			dir_q <= 1'b0;
		end else if (st_q == S_IDLE) begin
			idx_q <= '0;
			nptr_q <= '0;
			csum_q <= '0;
			if (start_save || start_rest) dir_q <= start_save;
		end else if (st_q == S_FETCH) begin
			if (!ent[CNS_OP_BIT]) cnt_q <= ent[6:0];
			if (!ent[CNS_OP_BIT] || ent == CNS_OP_COMMIT) idx_q <= idx_q + 5'd1;
		end else if (st_q == S_HI) begin
			addr_q[11:8] <= ent[3:0];
			idx_q <= idx_q + 5'd1;
		end else if (st_q == S_LO) begin
			addr_q[7:0] <= ent;
			idx_q <= idx_q + 5'd1;
		end else if (st_q == S_WAIT && xdone) begin
			// RL2 walk the segment bytes
			csum_q <= csum_q ^ xdata;
			nptr_q <= nptr_q + 1'b1;
			addr_q <= addr_q + 12'd1;
			if (cnt_q != '0) cnt_q <= cnt_q - 7'd1;
		end
	end

	cns_xfer u_xfer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.start(st_q == S_MOVE || st_q == S_CSUM),
		.save(dir_q),
		.csum(st_q == S_CSUM),
		.baddr(addr_q),
		.naddr(nptr_q),
		.csum_val(csum_q),
		.done(xdone),
		.data_q(xdata),
		.buf_o(buf_o),
		.buf_rdata(buf_rdata),
		.nvm_o(nvm_o),
		.nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata)
	);

	// ********************
	// Register read
	// ********************
	assign roff = reg_i.addr - CNS_A_SEG0;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_i.rd) begin
			reg_rdata <= '0;
			if (roff < 12'(CNS_SEG_N)) begin
				reg_rdata <= seg_q[roff[4:0]];
			end else begin
				unique case (reg_i.addr)
					// RL5 busy flag
					CNS_A_STAT: reg_rdata[CNS_B_BUSY] <= busy;
					CNS_A_ERR: reg_rdata[CNS_B_ERR] <= err_q;
					CNS_A_CTRL: reg_rdata[CNS_B_RELOAD:CNS_B_WEN] <= {reload_q, wen_q};
					CNS_A_SAVE: reg_rdata[CNS_B_SAVE] <= save_q;
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	// ********************
	// Assertions
	// ********************
	sequence s_start;
		start_save || start_rest;
	endsequence

	sequence s_run2;
		busy ##1 busy;
	endsequence

	AST_COMMIT_WR: assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
		hit(reg_i, CNS_A_COMMIT) && reg_i.wdata[CNS_B_COMMIT] |=> commit_pulse)
		else $error("commit write gave no commit pulse");

	AST_SEG_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn) // RL2
		!hit(reg_i, CNS_A_SEG0) |=> $stable(seg_q[0]))
		else $error("segment entry changed without a write");

	AST_OPC_COMMIT: assert property (@(posedge sys_clk) disable iff (!resetn) // RL3
		st_q == S_FETCH && ent == CNS_OP_COMMIT |=> commit_pulse && busy)
		else $error("commit opcode gave no commit pulse");

	AST_SEG_DEF: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
		$rose(resetn) |-> seg_q[15] == CNS_OP_COMMIT && seg_q[16] == CNS_OP_END)
		else $error("segment list default lacks commit then end");

	AST_BUSY: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
		s_start |=> s_run2)
		else $error("busy not shown after a start");

	AST_ERR: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
		st_q == S_CWAIT && xdone && !dir_q && xdata != csum_q |=> err_q && !busy)
		else $error("checksum mismatch not flagged");

	AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!resetn) // RL7
		start_rest |=> soft_reset_pulse && busy && !dir_q)
		else $error("reload did not reset and restore");

	AST_SELFCLR: assert property (@(posedge sys_clk) disable iff (!resetn) // RL8
		reload_q && sclk_rise && !rel_req |=> !reload_q)
		else $error("reload bit did not self-clear");

	AST_WPROT: assert property (@(posedge sys_clk) disable iff (!resetn) // RL9
		nvm_o.we |-> save_q && dir_q)
		else $error("memory written without an accepted save");

	AST_SAVE_END: assert property (@(posedge sys_clk) disable iff (!resetn) // RL10
		$fell(save_q) |-> !busy && $past(xdone))
		else $error("save bit fell before transfer end");

	AST_NO_SAVE: assert property (@(posedge sys_clk) disable iff (!resetn) // RL11
		save_req && !wen_q && !busy && !rel_req |=> !busy ##1 !nvm_o.req)
		else $error("protected save started a transfer");

endmodule // cns_store

// *** test/cns_mem_model.sv ***
// Nonvolatile memory and buffer register model facing the transfer ports
`timescale 1ns/1ps
module cns_mem_model (
	// Clock
	input wire logic sys_clk,
	// Buffer registers
	input cns_pkg::cns_buf_req_t buf_i,
	output logic [7:0] buf_rdata,
	// Nonvolatile memory
	input cns_pkg::cns_nvm_req_t nvm_i,
	output logic nvm_ack,
	output logic [7:0] nvm_rdata
);
	import cns_pkg::*;
	logic [7:0] nvm [1024];
	logic [7:0] bufr [4096];
	logic [2:0] wait_q;
	logic slow_q;
	int n_wr;

	initial begin
		nvm_ack = 1'b0;
		nvm_rdata = 8'h00;
		buf_rdata = 8'h00;
		wait_q = 3'h0;
		slow_q = 1'b0;
		n_wr = 0;
		foreach (nvm[i]) nvm[i] = 8'h00;
		foreach (bufr[i]) bufr[i] = 8'h00;
	end

	// ********************
	// Answers
	// ********************
	// Idle read lines toggle so a stale byte never looks valid
	always @(posedge sys_clk) begin
		nvm_ack <= 1'b0;
		nvm_rdata <= ~nvm_rdata;
		buf_rdata <= ~buf_rdata;
		if (buf_i.re) buf_rdata <= bufr[buf_i.addr];
		if (buf_i.we) bufr[buf_i.addr] <= buf_i.wdata;
		// Alternate prompt and slow acknowledges
		if (nvm_i.req && !nvm_ack) begin
			if (wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else begin
				nvm_ack <= 1'b1;
				slow_q <= !slow_q;
				wait_q <= slow_q ? 3'h0 : 3'h4;
				if (nvm_i.we) begin
					nvm[nvm_i.addr] <= nvm_i.wdata;
					n_wr = n_wr + 1;
				end else begin
					nvm_rdata <= nvm[nvm_i.addr];
				end
			end
		end
	end
endmodule // cns_mem_model

// *** test/config_nvm_store_restore_tb.sv ***
// Self-checking bench for the configuration store/restore block
`timescale 1ns/1ps
module config_nvm_store_restore_tb;
	import cns_pkg::*;
	logic sys_clk, resetn, spi_sclk, nvm_sel_n;
	logic commit_pulse, soft_reset_pulse, nvm_ack;
	logic [7:0] reg_rdata, buf_rdata, nvm_rdata, d;
	cns_reg_req_t reg_i;
	cns_buf_req_t buf_o;
	cns_nvm_req_t nvm_o;
	int n_errors = 0;
	int check_count = 0;
	int n_commit = 0;
	int n_soft = 0;

	cns_store i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_i(reg_i), .reg_rdata(reg_rdata),
		.spi_sclk(spi_sclk), .nvm_sel_n(nvm_sel_n), .commit_pulse(commit_pulse),
		.soft_reset_pulse(soft_reset_pulse), .buf_o(buf_o), .buf_rdata(buf_rdata),
		.nvm_o(nvm_o), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));
	cns_mem_model i_mem (.sys_clk(sys_clk), .buf_i(buf_o), .buf_rdata(buf_rdata),
		.nvm_i(nvm_o), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));

	// ********************
	// Clock and event counters
	// ********************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (commit_pulse === 1'b1) n_commit++;
		if (soft_reset_pulse === 1'b1) n_soft++;
	end

	// ********************
	// Shared tasks
	// ********************
	task check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1;
		reg_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge sys_clk);
		#1;
		reg_i.wr = 1'b0;
	endtask
	task rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		#1;
		reg_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		#1;
		reg_i.rd = 1'b0;
		v = reg_rdata;
	endtask
	// Polls status under a bound so a stuck transfer cannot hang the run
	task wait_idle;
		int k;
		k = 0;
		d = 8'h01;
		while (d[0] !== 1'b0 && k < 500) begin
			rd(CNS_A_STAT, d);
			k++;
		end
		check(d[0], 8'h00);
	endtask

	// ********************
	// Scenarios
	// ********************
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			rd(CNS_A_STAT + 12'(i), d);
			check(d, 8'h00);
		end
		for (int i = 0; i < CNS_SEG_N; i++) begin
			rd(CNS_A_SEG0 + 12'(i), d);
			check(d, CNS_SEG_DEF[i]);
		end
		rd(12'h100, d);
		check(d, 8'h00);
	endtask
	task t_commit;
		int c;
		c = n_commit;
		wr(CNS_A_COMMIT, 8'h01);
		repeat (2) @(posedge sys_clk);
		check(8'(n_commit - c), 8'h01);
		rd(CNS_A_COMMIT, d);
		check(d[0], 8'h00);
	endtask
	task t_protect;
		int w;
		w = i_mem.n_wr;
		wr(CNS_A_SAVE, 8'h01);
		rd(CNS_A_STAT, d);
		check(d[0], 8'h00);
		wait_idle();
		check(8'(i_mem.n_wr - w), 8'h00);
	endtask
	task t_save;
		int c;
		wr(CNS_A_SEG0, 8'h01);
		wr(CNS_A_SEG0 + 12'h1, 8'h00);
		wr(CNS_A_SEG0 + 12'h2, 8'h10);
		wr(CNS_A_SEG0 + 12'h3, CNS_OP_COMMIT);
		wr(CNS_A_SEG0 + 12'h4, CNS_OP_END);
		rd(CNS_A_SEG0 + 12'h2, d);
		check(d, 8'h10);
		i_mem.bufr[16] = 8'h5a;
		i_mem.bufr[17] = 8'hc3;
		// Protection lifted before the save
		wr(CNS_A_CTRL, 8'h01);
		c = n_commit;
		wr(CNS_A_SAVE, 8'h01);
		rd(CNS_A_STAT, d);
		check(d[0], 8'h01);
		rd(CNS_A_SAVE, d);
		check(d[0], 8'h01);
		wait_idle();
		rd(CNS_A_SAVE, d);
		check(d[0], 8'h00);
		check(i_mem.nvm[0], 8'h5a);
		check(i_mem.nvm[1], 8'hc3);
		check(i_mem.nvm[2], 8'h99);
		check(8'(n_commit - c), 8'h01);
	endtask
	task t_sel_high;
		int s;
		s = n_soft;
		wr(CNS_A_CTRL, 8'h03);
		repeat (3) @(posedge sys_clk);
		check(8'(n_soft - s), 8'h00);
		rd(CNS_A_STAT, d);
		check(d[0], 8'h00);
	endtask
	task t_restore;
		int s;
		@(posedge sys_clk);
		#1;
		nvm_sel_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		i_mem.bufr[16] = 8'h00;
		i_mem.bufr[17] = 8'h00;
		s = n_soft;
		wr(CNS_A_CTRL, 8'h03);
		rd(CNS_A_STAT, d);
		check(d[0], 8'h01);
		check(8'(n_soft - s), 8'h01);
		wait_idle();
		check(i_mem.bufr[16], 8'h5a);
		check(i_mem.bufr[17], 8'hc3);
		rd(CNS_A_ERR, d);
		check(d[0], 8'h00);
		// Serial clock idle, so the reload bit must still read set
		rd(CNS_A_CTRL, d);
		check(d[1], 8'h01);
		@(posedge sys_clk);
		#1;
		spi_sclk = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		spi_sclk = 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(CNS_A_CTRL, d);
		check(d[1], 8'h00);
	endtask
	task t_error;
		i_mem.nvm[0] = i_mem.nvm[0] ^ 8'h01;
		wr(CNS_A_CTRL, 8'h03);
		wait_idle();
		rd(CNS_A_ERR, d);
		check(d[0], 8'h01);
	endtask
	// Reset while idle, then a save through the default list
	task t_default;
		int w;
		int c;
		int k;
		@(posedge sys_clk);
		#1;
		resetn = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		rd(CNS_A_SEG0 + 12'h3, d);
		check(d, 8'h7f);
		rd(CNS_A_CTRL, d);
		check(d, 8'h00);
		wr(CNS_A_CTRL, 8'h01);
		w = i_mem.n_wr;
		c = n_commit;
		wr(CNS_A_SAVE, 8'h01);
		k = 0;
		d = 8'h01;
		while (d[0] !== 1'b0 && k < 4000) begin
			rd(CNS_A_STAT, d);
			k++;
		end
		check(d[0], 8'h00);
		// Whole space 0x000-0x231 plus one checksum byte
		check(8'((i_mem.n_wr - w) >> 8), 8'h02);
		check(8'(i_mem.n_wr - w), 8'h33);
		check(8'(n_commit - c), 8'h01);
	endtask

	// ********************
	// Main sequence and watchdog
	// ********************
	initial begin
		resetn = 1'b0;
		spi_sclk = 1'b0;
		nvm_sel_n = 1'b1;
		reg_i = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_commit();
		t_protect();
		t_save();
		t_sel_high();
		t_restore();
		t_error();
		t_default();
		end_sim();
	end
	initial begin
		#400000;
		n_errors++;
		end_sim();
	end
endmodule // config_nvm_store_restore_tb
